/* pkg/acs_pkg.sv */
// Shared constants and types of the self-calibration sequencer.
package acs_pkg;

  // ****************************************
  // Clock and rate constants
  // ****************************************
  localparam int CORE_HZ = 200_000_000;
  localparam int MCLK_HZ = 2_457_600;
  localparam int MOD_HZ = 19_200;
  // Master clock is approximated from the core clock; the ratio is truncated.
  localparam int MCLK_DIV = CORE_HZ / MCLK_HZ;
  localparam int MOD_RATIO = MCLK_HZ / MOD_HZ;
  localparam int MOD_CYCLES = MCLK_DIV * MOD_RATIO;
  localparam int MCNT_W = 20;
  localparam int DECIM_W = 8;

  // ****************************************
  // Sequence lengths in output periods
  // ****************************************
  localparam int ZS_PERIODS = 3;
  localparam int FS_PERIODS = 3;
  localparam int CONV_PERIODS = 3;
  localparam int CAL_PERIODS = ZS_PERIODS + FS_PERIODS;
  localparam int READY_PERIODS = CAL_PERIODS + CONV_PERIODS;
  localparam int PCNT_W = 2;

  // ****************************************
  // Data widths, codes and reset values
  // ****************************************
  localparam int RAW_W = 24;
  localparam int DATA_W = 16;
  localparam int ARITH_W = 33;
  localparam int DIV_STEPS = ARITH_W;
  localparam int DCNT_W = 6;
  localparam int UNI_SHIFT = 16;
  localparam int BIP_SHIFT = 17;
  localparam logic [1:0] CAL_IDLE = 2'h0;
  localparam logic [1:0] CAL_SELF = 2'h1;
  localparam logic [DATA_W-1:0] MID_CODE = 16'h8000;
  localparam logic [DATA_W-1:0] MAX_CODE = 16'hffff;
  localparam logic [RAW_W-1:0] ZS_RST = 24'h000000;
  localparam logic [RAW_W-1:0] FS_RST = 24'h400000;
  localparam logic [ARITH_W-1:0] COEF_RST = 33'h000000400;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ZS = 4'h2,
    ST_FS = 4'h4,
    ST_CONV = 4'h8
  } acs_state_e;

endpackage

/* pkg/acs_rate_if.sv */
// Interface carrying modulator and output-rate ticks between sequencer and rate generator.
`timescale 1ns/1ps
interface acs_rate_if;
  logic mod_tick;
  logic out_tick;
  logic restart;
  logic [7:0] decim;
  modport gen (output mod_tick, output out_tick, input restart, input decim);
  modport seq (input mod_tick, input out_tick, output restart, output decim);
endinterface

/* core/acs_rate_gen.sv */
// Modulator-cycle and output-period tick generator.
`timescale 1ns/1ps
module acs_rate_gen #(
  parameter int MOD_CYCLES = acs_pkg::MOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  acs_rate_if.gen rate
);
  import acs_pkg::*;

  logic [MCNT_W-1:0] mcnt;
  logic [MCNT_W-1:0] next_mcnt;
  logic [DECIM_W-1:0] pcnt;
  logic [DECIM_W-1:0] next_pcnt;
  logic [DECIM_W-1:0] plast;
  logic mod_tick;
  logic next_mod_tick;
  logic out_tick;
  logic next_out_tick;
  int gap;

  // ****************************************
  // Tick counters
  // ****************************************
  // A decimation ratio of zero is taken as one so the output never stalls.
  assign plast = (rate.decim == 8'h00) ? 8'h00 : rate.decim - 8'h01;

  always_comb
  begin
    next_mcnt = mcnt;
    next_pcnt = pcnt;
    next_mod_tick = mod_tick;
    next_out_tick = out_tick;
    if (clk_en)
    begin
      next_mod_tick = 1'b0;
      next_out_tick = 1'b0;
      if (rate.restart)
      begin
        next_mcnt = '0;
        next_pcnt = '0;
      end
      else if (mcnt == MCNT_W'(MOD_CYCLES - 1))
      begin
        next_mcnt = '0;
        next_mod_tick = 1'b1;
        if (pcnt >= plast)
        begin
          next_pcnt = '0;
          next_out_tick = 1'b1;
        end
        else
        begin
          next_pcnt = pcnt + 8'h01;
        end
      end
      else
      begin
        next_mcnt = mcnt + MCNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mcnt <= '0;
      pcnt <= '0;
      mod_tick <= 1'b0;
      out_tick <= 1'b0;
    end
    else
    begin
      mcnt <= next_mcnt;
      pcnt <= next_pcnt;
      mod_tick <= next_mod_tick;
      out_tick <= next_out_tick;
    end
  end

  assign rate.mod_tick = mod_tick;
  assign rate.out_tick = out_tick;

  // ****************************************
  // Checks
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      gap <= 0;
    else if (clk_en)
      gap <= rate.restart ? 0 : (mod_tick ? 1 : gap + 1);
  end

  a_mod_period: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mod_tick && gap > 1 && $past(clk_en)) |-> gap == MOD_CYCLES)
    else $error("modulator tick spacing wrong");

endmodule

/* core/acs_cal_seq.sv */
// Self-calibration sequencer of the sigma-delta converter control logic.
//
// Operation
// - Modulator ticks at master clock over 128; filter decimates to output rate.
// - Mode code 0,1 starts a self-calibration.
// - Zero-scale result goes to zero register, full-scale result to full register.
// - Offset and slope come from both points; 33-bit math, 16-bit result.
// - Unipolar zero-scale point uses both inputs shorted to internal bias.
// - Amplifier uses the selected gain during the zero-scale conversion.
// - Full-scale step converts reference over gain at the selected gain.
// - Calibration lasts three zero-scale plus three full-scale output periods.
// - Mode bits return to 0,0 when calibration ends.
// - Result-ready goes high at start, stays high until a new word.
// - Result-ready goes low nine output periods after the command.
// - Raising result-ready may take up to one modulator cycle.
// - Bipolar maps the shorted-input point to midscale.
// - Polarity changes only coding, not calibration points or input conditioning.
`timescale 1ns/1ps
module acs_cal_seq #(
  parameter int MOD_CYCLES = acs_pkg::MOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cal_wr,
  input wire logic [1:0] cal_wdata,
  input wire logic gain_sel_hi,
  input wire logic gain_sel_lo,
  input wire logic bipolar,
  input wire logic [acs_pkg::DECIM_W-1:0] decim_ratio,
  input wire logic [acs_pkg::RAW_W-1:0] conv_data,
  input wire logic data_read,
  output logic cal_mode_hi,
  output logic cal_mode_lo,
  output logic result_ready_n,
  output logic short_analog_in,
  output logic ref_div_gain,
  output logic [1:0] pga_gain,
  output logic [acs_pkg::RAW_W-1:0] zs_cal,
  output logic [acs_pkg::RAW_W-1:0] fs_cal,
  output logic [acs_pkg::DATA_W-1:0] data_out
);
  import acs_pkg::*;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  acs_state_e state;
  acs_state_e next_state;
  logic [PCNT_W-1:0] pcnt;
  logic [PCNT_W-1:0] next_pcnt;
  logic next_cal_mode_hi;
  logic next_cal_mode_lo;
  logic next_result_ready_n;
  logic next_short_analog_in;
  logic next_ref_div_gain;
  logic [1:0] next_pga_gain;
  logic [RAW_W-1:0] next_zs_cal;
  logic [RAW_W-1:0] next_fs_cal;
  logic [DATA_W-1:0] next_data_out;
  logic [ARITH_W-1:0] coef;
  logic [ARITH_W-1:0] next_coef;
  logic [RAW_W:0] rem;
  logic [RAW_W:0] next_rem;
  logic [DCNT_W-1:0] dcnt;
  logic [DCNT_W-1:0] next_dcnt;
  logic div_busy;
  logic next_div_busy;
  logic signed [RAW_W:0] span;
  logic [RAW_W+1:0] rem_try;
  logic cal_go;
  logic out_tick;

  acs_rate_if rate ();

  acs_rate_gen #(
    .MOD_CYCLES(MOD_CYCLES)
  ) u_rate (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .rate(rate)
  );

  // ****************************************
  // Calibrated code
  // ****************************************
  // Unipolar spans zero-scale to full-scale over the whole code range; bipolar
  // puts the zero-scale point at midscale and full-scale at the top.
  function automatic logic [DATA_W-1:0] acs_code(
    input logic [RAW_W-1:0] raw,
    input logic [RAW_W-1:0] zero,
    input logic [ARITH_W-1:0] k,
    input logic bip
  );
    logic signed [RAW_W:0] diff;
    logic signed [RAW_W+ARITH_W+1:0] prod;
    logic signed [RAW_W+ARITH_W+1:0] val;
    diff = $signed({1'b0, raw}) - $signed({1'b0, zero});
    prod = diff * $signed({1'b0, k});
    if (bip)
      val = (prod >>> BIP_SHIFT) + $signed({43'h0, MID_CODE});
    else
      val = prod >>> UNI_SHIFT;
    if (val < 0)
      return DATA_RST;
    else if (val > $signed({43'h0, MAX_CODE}))
      return MAX_CODE;
    else
      return val[DATA_W-1:0];
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  // Only code 0,1 is acted on here; any other mode code leaves the block alone.
  assign cal_go = cal_wr && (cal_wdata == CAL_SELF);
  assign out_tick = rate.out_tick;
  assign rate.restart = cal_go;
  assign rate.decim = decim_ratio;
  assign span = $signed({1'b0, fs_cal}) - $signed({1'b0, zs_cal});
  assign rem_try = {rem, (dcnt == DCNT_W'(DIV_STEPS - 1))};

  always_comb
  begin
    next_state = state;
    next_pcnt = pcnt;
    next_cal_mode_hi = cal_mode_hi;
    next_cal_mode_lo = cal_mode_lo;
    next_result_ready_n = result_ready_n;
    next_zs_cal = zs_cal;
    next_fs_cal = fs_cal;
    next_data_out = data_out;
    next_coef = coef;
    next_rem = rem;
    next_dcnt = dcnt;
    next_div_busy = div_busy;
    next_pga_gain = pga_gain;
    if (clk_en)
    begin
      next_pga_gain = {gain_sel_hi, gain_sel_lo};
      if (div_busy)
      begin
        // Restoring division of two to the 32nd by the span, one bit a cycle.
        if (rem_try >= {1'b0, span[RAW_W:0]})
        begin
          next_rem = (RAW_W+1)'(rem_try - {1'b0, span[RAW_W:0]});
          next_coef = {coef[ARITH_W-2:0], 1'b1};
        end
        else
        begin
          next_rem = rem_try[RAW_W:0];
          next_coef = {coef[ARITH_W-2:0], 1'b0};
        end
        next_dcnt = dcnt - DCNT_W'(1);
        next_div_busy = (dcnt != '0);
      end
      if (cal_go)
      begin
        // Immediate rise is well inside the one modulator cycle allowed.
        next_state = ST_ZS;
        next_pcnt = '0;
        next_cal_mode_hi = CAL_SELF[1];
        next_cal_mode_lo = CAL_SELF[0];
        next_result_ready_n = 1'b1;
        next_div_busy = 1'b0;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            if (out_tick)
            begin
              next_data_out = acs_code(conv_data, zs_cal, coef, bipolar);
              next_result_ready_n = 1'b0;
            end
            else if (data_read)
            begin
              next_result_ready_n = 1'b1;
            end
          end
          ST_ZS:
          begin
            if (out_tick)
            begin
              if (pcnt == PCNT_W'(ZS_PERIODS - 1))
              begin
                next_zs_cal = conv_data;
                next_state = ST_FS;
                next_pcnt = '0;
              end
              else
              begin
                next_pcnt = pcnt + PCNT_W'(1);
              end
            end
          end
          ST_FS:
          begin
            if (out_tick)
            begin
              if (pcnt == PCNT_W'(FS_PERIODS - 1))
              begin
                next_fs_cal = conv_data;
                next_state = ST_CONV;
                next_pcnt = '0;
                next_cal_mode_hi = CAL_IDLE[1];
                next_cal_mode_lo = CAL_IDLE[0];
                next_div_busy = 1'b1;
                next_dcnt = DCNT_W'(DIV_STEPS - 1);
                next_rem = '0;
                next_coef = '0;
              end
              else
              begin
                next_pcnt = pcnt + PCNT_W'(1);
              end
            end
          end
          ST_CONV:
          begin
            // A span that is not positive leaves a zero slope rather than garbage.
            if (div_busy && span <= 0)
            begin
              next_div_busy = 1'b0;
              next_coef = '0;
            end
            if (out_tick)
            begin
              if (pcnt == PCNT_W'(CONV_PERIODS - 1))
              begin
                next_data_out = acs_code(conv_data, zs_cal, coef, bipolar);
                next_result_ready_n = 1'b0;
                next_state = ST_IDLE;
                next_pcnt = '0;
              end
              else
              begin
                next_pcnt = pcnt + PCNT_W'(1);
              end
            end
          end
        endcase
      end
    end
    // Input conditioning follows the step only; polarity plays no part.
    next_short_analog_in = (next_state == ST_ZS);
    next_ref_div_gain = (next_state == ST_FS);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      pcnt <= '0;
      cal_mode_hi <= CAL_IDLE[1];
      cal_mode_lo <= CAL_IDLE[0];
      result_ready_n <= 1'b1;
      short_analog_in <= 1'b0;
      ref_div_gain <= 1'b0;
      pga_gain <= 2'h0;
      zs_cal <= ZS_RST;
      fs_cal <= FS_RST;
      data_out <= DATA_RST;
      coef <= COEF_RST;
      rem <= '0;
      dcnt <= '0;
      div_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pcnt <= next_pcnt;
      cal_mode_hi <= next_cal_mode_hi;
      cal_mode_lo <= next_cal_mode_lo;
      result_ready_n <= next_result_ready_n;
      short_analog_in <= next_short_analog_in;
      ref_div_gain <= next_ref_div_gain;
      pga_gain <= next_pga_gain;
      zs_cal <= next_zs_cal;
      fs_cal <= next_fs_cal;
      data_out <= next_data_out;
      coef <= next_coef;
      rem <= next_rem;
      dcnt <= next_dcnt;
      div_busy <= next_div_busy;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  int per_cnt;
  logic cal_seen;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      per_cnt <= 0;
      cal_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cal_go)
      begin
        per_cnt <= 0;
        cal_seen <= 1'b1;
      end
      else
      begin
        if (out_tick && per_cnt < 15)
          per_cnt <= per_cnt + 1;
        if (!next_result_ready_n)
          cal_seen <= 1'b0;
      end
    end
  end

  a_ready_high_start: assert property ((clk_en && cal_go) |=> result_ready_n)
    else $error("ready not raised at calibration start");

  a_ready_nine_periods: assert property (
    ($fell(result_ready_n) && $past(cal_seen)) |-> per_cnt == READY_PERIODS)
    else $error("ready fell at wrong period count");

  a_mode_six_periods: assert property (
    $fell(cal_mode_lo) |-> (per_cnt == CAL_PERIODS && !cal_mode_hi))
    else $error("mode bits cleared at wrong period count");

  a_mode_clear_end: assert property (
    (state == ST_CONV) |-> (!cal_mode_hi && !cal_mode_lo))
    else $error("mode bits not cleared after calibration");

  a_short_zero_step: assert property (
    short_analog_in == (state == ST_ZS) && !(short_analog_in && ref_div_gain) &&
    (!short_analog_in || (cal_mode_lo && !cal_mode_hi)))
    else $error("input short does not follow zero-scale step");

  a_ref_full_step: assert property (
    ref_div_gain == (state == ST_FS) && (!ref_div_gain || (cal_mode_lo && !cal_mode_hi)))
    else $error("reference-over-gain input does not follow full-scale step");

  a_pga_gain_follow: assert property (
    clk_en |=> pga_gain == $past({gain_sel_hi, gain_sel_lo}))
    else $error("amplifier gain differs from selection");

  a_zs_store_point: assert property (
    ($fell(short_analog_in) && state == ST_FS) |-> zs_cal == $past(conv_data))
    else $error("zero-scale point not stored");

  a_fs_store_point: assert property (
    ($fell(ref_div_gain) && state == ST_CONV) |-> fs_cal == $past(conv_data))
    else $error("full-scale point not stored");

  a_no_cal_data: assert property (
    (state == ST_ZS || state == ST_FS) |=> $stable(data_out))
    else $error("calibration conversion reached the data register");

  a_coef_done: assert property (
    (state == ST_CONV && out_tick && pcnt == PCNT_W'(CONV_PERIODS - 1)) |-> !div_busy)
    else $error("coefficient not ready for first result");

endmodule

/* dv/acs_host_model.sv */
// Host-side model that writes the calibration mode and reads the data register.
`timescale 1ns/1ps
module acs_host_model #(
  parameter int MOD_CYCLES = 64
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic result_ready_n,
  output logic cal_wr,
  output logic [1:0] cal_wdata,
  output logic data_read,
  output logic ready_seen
);
  // ****************************************
  // Host behaviour
  // ****************************************
  int mask_cnt;

  initial
  begin
    cal_wr = 1'b0;
    cal_wdata = 2'h0;
    data_read = 1'b0;
  end

  // The ready line is not trusted for one modulator cycle after a command, since the
  // device may need that long to raise it.
  assign ready_seen = (mask_cnt == 0) && (result_ready_n === 1'b0);

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      mask_cnt <= 0;
    else if (cal_wr)
      mask_cnt <= MOD_CYCLES;
    else if (mask_cnt > 0)
      mask_cnt <= mask_cnt - 1;
  end

  // Commands may come at any moment, also after a gain or polarity change.
  task automatic write_mode(input logic [1:0] code);
    @(posedge core_clk);
    cal_wr <= 1'b1;
    cal_wdata <= code;
    @(posedge core_clk);
    cal_wr <= 1'b0;
    cal_wdata <= ~code;
  endtask

  task automatic read_data();
    @(posedge core_clk);
    data_read <= 1'b1;
    @(posedge core_clk);
    data_read <= 1'b0;
  endtask
endmodule

/* dv/acs_cal_seq_tb_top.sv */
// Self-checking testbench of the self-calibration sequencer.
`timescale 1ns/1ps
module acs_cal_seq_tb_top;
  import acs_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int MODC = 64;
  localparam int DEC = 2;
  localparam int P = MODC * DEC;
  logic core_clk, rst_b, clk_en, gain_sel_hi, gain_sel_lo, bipolar;
  logic cal_wr, data_read, ready_seen;
  logic [1:0] cal_wdata;
  logic [DECIM_W-1:0] decim_ratio;
  logic [RAW_W-1:0] conv_data;
  logic cal_mode_hi, cal_mode_lo, result_ready_n, short_analog_in, ref_div_gain;
  logic [1:0] pga_gain;
  logic [RAW_W-1:0] zs_cal, fs_cal;
  logic [DATA_W-1:0] data_out;
  int errors, total_checks, cur, cycles;

  acs_cal_seq #(.MOD_CYCLES(MODC)) dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .cal_wr(cal_wr), .cal_wdata(cal_wdata), .gain_sel_hi(gain_sel_hi),
    .gain_sel_lo(gain_sel_lo), .bipolar(bipolar), .decim_ratio(decim_ratio),
    .conv_data(conv_data), .data_read(data_read), .cal_mode_hi(cal_mode_hi),
    .cal_mode_lo(cal_mode_lo), .result_ready_n(result_ready_n),
    .short_analog_in(short_analog_in), .ref_div_gain(ref_div_gain), .pga_gain(pga_gain),
    .zs_cal(zs_cal), .fs_cal(fs_cal), .data_out(data_out));

  acs_host_model #(.MOD_CYCLES(MODC)) host (.core_clk(core_clk), .rst_b(rst_b),
    .result_ready_n(result_ready_n), .cal_wr(cal_wr), .cal_wdata(cal_wdata),
    .data_read(data_read), .ready_seen(ready_seen));

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // The ceiling leaves ample room over the roughly 7200 cycles the tests need.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      $display("MISMATCH timeout expected finish seen hang");
      complete_run();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic go(input int n);
    repeat (n - cur) @(posedge core_clk);
    cur = n;
  endtask

  function automatic logic [15:0] exp_code(input logic bip, input logic [23:0] z, f, r);
    longint coef, d, v;
    coef = (f > z) ? (longint'(1) <<< 32) / (longint'(f) - longint'(z)) : 0;
    d = longint'(r) - longint'(z);
    v = bip ? ((d * coef) >>> 17) + 32768 : (d * coef) >>> 16;
    if (v < 0)
      v = 0;
    if (v > 65535)
      v = 65535;
    return v[15:0];
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_check();
    @(posedge core_clk);
    #1;
    chk("cal_mode", 2'h0, {cal_mode_hi, cal_mode_lo});
    chk("ready_n", 1'b1, result_ready_n);
    chk("zs_cal", ZS_RST, zs_cal);
    chk("fs_cal", FS_RST, fs_cal);
    $display("test reset done");
  endtask

  task automatic other_codes();
    for (int c = 0; c < 4; c++)
    begin
      if (c == 1)
        continue;
      host.write_mode(c[1:0]);
      cur = 0;
      go(1);
      #1;
      chk("cal_mode", 2'h0, {cal_mode_hi, cal_mode_lo});
      chk("short", 1'b0, short_analog_in);
    end
    $display("test other codes done");
  endtask

  task automatic cal_run(input logic bip, input logic [1:0] g, input logic [23:0] zv, fv, rv);
    @(posedge core_clk);
    bipolar <= bip;
    gain_sel_hi <= g[1];
    gain_sel_lo <= g[0];
    conv_data <= zv;
    host.write_mode(2'h1);
    cur = 0;
    go(1);
    #1;
    chk("cal_mode", 2'h1, {cal_mode_hi, cal_mode_lo});
    chk("ready_n", 1'b1, result_ready_n);
    chk("short", 1'b1, short_analog_in);
    chk("pga_gain", g, pga_gain);
    chk("ready_seen", 1'b0, ready_seen);
    go(3 * P);
    #1;
    chk("short", 1'b1, short_analog_in);
    go(3 * P + 2);
    conv_data <= fv;
    #1;
    chk("zs_cal", zv, zs_cal);
    chk("short", 1'b0, short_analog_in);
    chk("ref", 1'b1, ref_div_gain);
    chk("pga_gain", g, pga_gain);
    go(4 * P);
    host.read_data();
    cur = cur + 2;
    #1;
    chk("ready_n", 1'b1, result_ready_n);
    go(6 * P);
    #1;
    chk("cal_mode", 2'h1, {cal_mode_hi, cal_mode_lo});
    go(6 * P + 2);
    conv_data <= rv;
    #1;
    chk("fs_cal", fv, fs_cal);
    chk("cal_mode", 2'h0, {cal_mode_hi, cal_mode_lo});
    chk("ref", 1'b0, ref_div_gain);
    go(9 * P);
    #1;
    chk("ready_n", 1'b1, result_ready_n);
    chk("ready_seen", 1'b0, ready_seen);
    go(9 * P + 2);
    #1;
    chk("ready_n", 1'b0, result_ready_n);
    chk("ready_seen", 1'b1, ready_seen);
    chk("data_out", exp_code(bip, zv, fv, rv), data_out);
    $display("test calibration bip %0d gain %0d done", bip, g);
  endtask

  task automatic read_release();
    host.read_data();
    #1;
    chk("ready_n", 1'b1, result_ready_n);
    $display("test read release done");
  endtask

  task automatic restart_run();
    host.write_mode(2'h1);
    cur = 0;
    go(2 * P);
    host.write_mode(2'h1);
    cur = 0;
    go(3 * P);
    #1;
    chk("short", 1'b1, short_analog_in);
    chk("cal_mode", 2'h1, {cal_mode_hi, cal_mode_lo});
    go(9 * P + 2);
    #1;
    chk("ready_n", 1'b0, result_ready_n);
    $display("test restart done");
  endtask

  // Sixteen disabled cycles in the second period must push every step back by sixteen.
  task automatic freeze_run();
    host.write_mode(2'h1);
    cur = 0;
    go(P + 10);
    clk_en <= 1'b0;
    go(P + 26);
    clk_en <= 1'b1;
    go(3 * P + 16);
    #1;
    chk("short", 1'b1, short_analog_in);
    go(3 * P + 17);
    #1;
    chk("short", 1'b0, short_analog_in);
    go(9 * P + 16);
    #1;
    chk("ready_n", 1'b1, result_ready_n);
    go(9 * P + 17);
    #1;
    chk("ready_n", 1'b0, result_ready_n);
    $display("test clock enable freeze done");
  endtask

  initial
  begin
    errors = 0;
    total_checks = 0;
    cycles = 0;
    cur = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    gain_sel_hi = 1'b0;
    gain_sel_lo = 1'b0;
    bipolar = 1'b0;
    decim_ratio = DEC;
    conv_data = 24'h000000;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    reset_check();
    other_codes();
    cal_run(1'b0, 2'h0, 24'h100000, 24'h500000, 24'h300000);
    read_release();
    cal_run(1'b1, 2'h1, 24'h100000, 24'h500000, 24'h000000);
    cal_run(1'b1, 2'h2, 24'h100000, 24'h500000, 24'h600000);
    cal_run(1'b0, 2'h3, 24'h400000, 24'h400000, 24'h123456);
    restart_run();
    freeze_run();
    complete_run();
  end
endmodule
